// ---- inc/pdps_cfg.svh ----
// pdps_cfg.svh: constants for the phase step controller
// assumes inclusion by its bare name from the package and modules
`ifndef PDPS_CFG_SVH
`define PDPS_CFG_SVH
`define PDPS_SEL_ALL      3'h0
`define PDPS_SEL_FB       3'h1
`define PDPS_SEL_OUT0     3'h2
`define PDPS_SEL_OUT_LAST 3'h6
`define PDPS_NUM_OUT      5
`define PDPS_PHASE_BITS   8
`define PDPS_STEPS_PER_VCO 8
`define PDPS_SETTLE_CYC   4
`define PDPS_MIN_HOLD_CYC 2
`endif

// ---- inc/pdps_pkg.sv ----
// pdps_pkg.sv: types shared by the phase step controller files
// assumes pdps_cfg.svh is on the include path
`include "pdps_cfg.svh"
package pdps_pkg;
	typedef enum logic [1:0] {
		PDPS_IDLE,
		PDPS_SHIFT,
		PDPS_WAIT_REL,
		PDPS_SETTLE
	} pdps_state_t;

	typedef struct packed {
		logic       up;
		logic [2:0] sel;
	} pdps_req_t;
endpackage : pdps_pkg

// ---- hdl/pdps_phase_acc.sv ----
// pdps_phase_acc.sv: per counter phase offset registers, one step each
// assumes a one-cycle step strobe with a decoded counter mask
`timescale 1ns/100ps
`include "pdps_cfg.svh"
module pdps_phase_acc
	import pdps_pkg::*;
#(
	parameter int NUM_CNT = `PDPS_NUM_OUT + 1,
	parameter int PW      = `PDPS_PHASE_BITS
) (
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                resetn_in,
	// step command
	input  wire logic                step_in,
	input  wire logic                up_in,
	input  wire logic [NUM_CNT-1:0]  mask_in,
	// phase offsets in eighths of the vco period
	output logic [NUM_CNT*PW-1:0]    phase_out
);
	genvar g;
	generate
		for (g = 0; g < NUM_CNT; g++) begin : g_cnt
			logic [PW-1:0] ph_r;
			logic [PW-1:0] ph_nxt;
			always_comb begin
				ph_nxt = ph_r;
				if (step_in && mask_in[g]) begin
					ph_nxt = up_in ? ph_r + PW'(1) : ph_r - PW'(1);
				end
			end
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					ph_r <= '0;
				end else begin
					ph_r <= ph_nxt;
				end
			end
			assign phase_out[g*PW +: PW] = ph_r;
		end
	endgenerate
endmodule : pdps_phase_acc

// ---- hdl/pdps_ctrl.sv ----
// pdps_ctrl.sv: dynamic phase step handshake for the pll counters
// assumes clk_in is the free running scan clock from the core
`timescale 1ns/100ps
`include "pdps_cfg.svh"
module pdps_ctrl
	import pdps_pkg::*;
#(
	parameter int NUM_OUT    = `PDPS_NUM_OUT,
	parameter int PW         = `PDPS_PHASE_BITS,
	parameter int SETTLE_CYC = `PDPS_SETTLE_CYC
) (
	// scan clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       resetn_in,
	// step control from core
	input  wire logic                       phase_step_in,
	input  wire logic                       shift_direction_in,
	input  wire logic [2:0]                 counter_select_in,
	// handshake and status
	output logic                            shift_done_out,
	output logic                            select_err_out,
	// phase offsets, feedback first then outputs
	output logic [(NUM_OUT+1)*PW-1:0]       phase_out
);
	localparam int CW = $clog2(SETTLE_CYC + 1);

	pdps_state_t        state_r, state_nxt;
	pdps_req_t          req_r, req_nxt;
	logic [CW-1:0]      cnt_r, cnt_nxt;
	logic               done_r, done_nxt;
	logic               err_r, err_nxt;
	logic               step_pulse;
	logic [NUM_OUT:0]   mask;
	logic               sel_legal;

	// bit 0 is the feedback counter, bits 1..NUM_OUT the outputs
	always_comb begin
		mask = '0;
		sel_legal = 1'b1;
		if (req_r.sel == `PDPS_SEL_ALL) begin
			mask = '1;
			mask[0] = 1'b0;
		end else if (req_r.sel == `PDPS_SEL_FB) begin
			mask[0] = 1'b1;
		end else if (req_r.sel <= `PDPS_SEL_OUT_LAST) begin
			mask[req_r.sel - `PDPS_SEL_OUT0 + 3'h1] = 1'b1;
		end else begin
			sel_legal = 1'b0;
		end
	end

	always_comb begin
		state_nxt  = state_r;
		req_nxt    = req_r;
		cnt_nxt    = cnt_r;
		done_nxt   = done_r;
		err_nxt    = err_r;
		step_pulse = 1'b0;
		unique case (state_r)
			PDPS_IDLE: begin
				if (phase_step_in) begin
					// capture on the edge so later changes cannot disturb this step
					req_nxt.up  = shift_direction_in;
					req_nxt.sel = counter_select_in;
					state_nxt   = PDPS_SHIFT;
					done_nxt    = 1'b0;
				end
			end
			PDPS_SHIFT: begin
				step_pulse = sel_legal;
				err_nxt    = ~sel_legal;
				state_nxt  = PDPS_WAIT_REL;
			end
			PDPS_WAIT_REL: begin
				// a step held high longer still yields a single increment
				if (!phase_step_in) begin
					state_nxt = PDPS_SETTLE;
					cnt_nxt   = '0;
				end
			end
			PDPS_SETTLE: begin
				if (cnt_r == CW'(SETTLE_CYC - 1)) begin
					state_nxt = PDPS_IDLE;
					done_nxt  = 1'b1;
				end else begin
					cnt_nxt = cnt_r + CW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= PDPS_IDLE;
			req_r   <= '0;
			cnt_r   <= '0;
			done_r  <= 1'b1;
			err_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			req_r   <= req_nxt;
			cnt_r   <= cnt_nxt;
			done_r  <= done_nxt;
			err_r   <= err_nxt;
		end
	end

	assign shift_done_out = done_r;
	assign select_err_out = err_r;

	pdps_phase_acc #(
		.NUM_CNT (NUM_OUT + 1),
		.PW      (PW)
	) u_acc (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.step_in   (step_pulse),
		.up_in     (req_r.up),
		.mask_in   (mask),
		.phase_out (phase_out)
	);
endmodule : pdps_ctrl

// ---- dv/pdps_chk.sv ----
// pdps_chk.sv: handshake and step checks
// assumes bind to pdps_ctrl with settle count 4
`timescale 1ns/100ps
module pdps_chk #(parameter int NUM_OUT = 5, parameter int PW = 8) (
	input  wire logic                        clk_in,
	input  wire logic                        resetn_in,
	input  wire logic                        phase_step_in,
	input  wire logic                        shift_direction_in,
	input  wire logic [2:0]                  counter_select_in,
	input  wire logic                        shift_done_out,
	input  wire logic                        select_err_out,
	input  wire logic [(NUM_OUT+1)*PW-1:0]   phase_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	wire t = shift_done_out && phase_step_in;
	AST_FALL: assert property (t |=> !shift_done_out) else $error("no fall");
	// settle length of 4 matches the default settle count of the design
	AST_SETTLE: assert property ($fell(phase_step_in) && !shift_done_out |=>
		!shift_done_out[*4] ##1 shift_done_out) else $error("settle");
	AST_MOVE: assert property ($changed(phase_out) |->
		!$past(shift_done_out) && $past(shift_done_out, 2)) else $error("stray move");
	AST_FB_UP: assert property (t && shift_direction_in && counter_select_in == 3'h1 |=>
		##1 phase_out[7:0] == $past(phase_out[7:0], 2) + 8'h1) else $error("fb up");
	AST_C4_DN: assert property (t && !shift_direction_in && counter_select_in == 3'h6 |=>
		##1 phase_out[47:40] == $past(phase_out[47:40], 2) - 8'h1) else $error("c4 down");
	AST_ERR: assert property (t |=> ##1 select_err_out == ($past(counter_select_in, 2) == 3'h7))
		else $error("err flag");
	cover property (t && counter_select_in == 3'h0);
	cover property (t && counter_select_in == 3'h7);
	cover property ($rose(shift_done_out));
endmodule : pdps_chk
bind pdps_ctrl pdps_chk #(.NUM_OUT(NUM_OUT), .PW(PW)) i_pdps_chk (.*);

// ---- dv/pdps_core.sv ----
// pdps_core.sv: core side model of the step handshake
// assumes free running clk_in, drives on falling edge
`timescale 1ns/100ps
module pdps_core (
	input  wire logic  clk_in,
	input  wire logic  done_in,
	output logic       step_out = 0,
	output logic       up_out = 0,
	output logic [2:0] sel_out = 0
);
	task automatic step(input logic up, input logic [2:0] sel, input int hold);
		int n = 0;
		@(negedge clk_in);
		{up_out, sel_out, step_out} = {up, sel, 1'b1};
		while (done_in === 1'b1 || n < hold) begin
			@(negedge clk_in);
			n++;
		end
		// select and direction scrambled once released, busy block must ignore them
		{up_out, sel_out, step_out} = {~up, ~sel, 1'b0};
		while (done_in !== 1'b1) @(negedge clk_in);
	endtask : step
endmodule : pdps_core

// ---- dv/testbench.sv ----
// testbench.sv: random phase steps, queued expectations
// assumes pdps_ctrl with default widths
`timescale 1ns/100ps
module testbench;
	logic clk_in = 0, resetn_in = 0;
	logic phase_step_in, shift_direction_in, shift_done_out, select_err_out;
	logic [2:0] counter_select_in;
	logic [47:0] phase_out, ph = 0;
	logic [48:0] q[$];
	logic [31:0] r = 32'h356d;
	logic [7:0] d;
	int failures = 0, n_checks = 0;
	logic done_q = 1'b1;
	always #25 clk_in = ~clk_in;
	pdps_ctrl i_pdps_ctrl (.*);
	pdps_core i_pdps_core (.clk_in, .done_in(shift_done_out), .step_out(phase_step_in),
		.up_out(shift_direction_in), .sel_out(counter_select_in));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	task stop_test;
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [48:0] e);
		n_checks++;
		if ({select_err_out, phase_out} !== e) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, {select_err_out, phase_out}, e);
		end
	endtask : cmp
	// outputs are settled at the falling edge, so the compare never races the launching edge
	always @(negedge clk_in) begin
		if (resetn_in && shift_done_out === 1'b1 && !done_q) cmp(q.pop_front());
		done_q <= shift_done_out;
	end
	// 60 steps take well under 1000 cycles; four times that marks a hang
	initial begin
		#200000;
		failures++;
		stop_test;
	end
	initial begin
		repeat (4) @(negedge clk_in);
		resetn_in = 1;
		for (int i = 0; i < 60; i++) begin
			r = xs(r);
			if (i < 8) r[2:0] = 3'(i);
			d = r[3] ? 8'h1 : 8'hff;
			for (int k = 0; k < 6; k++) if (k ? (r[2:0] == 0 || r[2:0] == k + 1) : r[2:0] == 1) ph[k*8+:8] += d;
			q.push_back({r[2:0] == 3'h7, ph});
			i_pdps_core.step(r[3], r[2:0], 2 + r[5:4]);
		end
		repeat (2) @(negedge clk_in);
		stop_test;
	end
endmodule : testbench
